// file: pcar_cfg.svh
// Timing and format constants for the pin configured converter readout
`ifndef PCAR_CFG_SVH
`define PCAR_CFG_SVH
`define PCAR_CLK_HZ 10000000
`define PCAR_XTAL_HZ 32768
// Half crystal period in system clocks, rounded down (shorter time)
`define PCAR_HALF_XTAL_CYC ((`PCAR_CLK_HZ / `PCAR_XTAL_HZ) / 2)
// Update period 50.54 ms, printed figure in microseconds
`define PCAR_UPDATE_PERIOD_US 50540
`define PCAR_UPDATE_PERIOD_CYC ((`PCAR_UPDATE_PERIOD_US * (`PCAR_CLK_HZ / 1000)) / 1000)
`define PCAR_RESULT_BITS 24
`define PCAR_GAIN_NARROW 16
`define PCAR_GAIN_WIDE 1
`define PCAR_OFFSET_MSB 24'h800000
`endif

// file: pcar_pkg.sv
// Types shared by the converter readout block
package pcar_pkg;
    typedef enum logic [3:0] {
        PCAR_IDLE = 4'b0001,
        PCAR_CONV = 4'b0010,
        PCAR_WAIT = 4'b0100,
        PCAR_SHIFT = 4'b1000
    } pcar_state_t;
endpackage

// file: pcar_buf.sv
// Two-entry result buffer with valid and ready on both sides
module pcar_buf #(
    parameter int WIDTH = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2]; // Storage slots
    logic wr_ptr; // Slot written next
    logic rd_ptr; // Slot read next
    logic [1:0] count; // Words held
    logic push;
    logic pop;
    assign push = in_valid_i && (count != 2'h2);
    assign pop = out_valid_o && out_ready_i;

    // Occupancy and pointers; flush drops everything
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (flush_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Word storage
    always_ff @(posedge clk_i) begin
        if (push && !flush_i) mem[wr_ptr] <= in_data_i;
    end

    // Ready and valid from the registered count
    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];
endmodule // pcar_buf

// file: pcar_readout.sv
// Converter control and read-only serial readout, device side
//Contract
//RULE1 - Each result is a 24-bit word
//RULE2 - Interface is read only, master or slave
//RULE3 - No registers; configuration from two pins
//RULE4 - Gain 1 or 16 from span pin
//RULE5 - Results arrive at fixed 19.79 Hz
//RULE6 - Filter notches at 50 and 60 Hz
//RULE7 - Timing from crystal multiplied by PLL
//RULE8 - Output words are offset binary
//RULE9 - Slave host drives clock and select
//RULE10 - Master waits half to 1.5 crystal periods
//RULE11 - Ready line returns high after read
//RULE12 - Span low narrow, span high wide
//RULE13 - Select high aborts, floats lines, discards
//RULE14 - Ready rises on start; shift on falls
//RULE15 - Master shift period equals crystal period
//RULE16 - 24 bits MSB first, pauses allowed
`include "pcar_cfg.svh"
module pcar_readout #(
    parameter int UPDATE_CYC = `PCAR_UPDATE_PERIOD_CYC,
    parameter int HALF_CYC = `PCAR_HALF_XTAL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic master_mode_n_i,
    input wire logic span_select_i,
    input wire logic excitation_route_select_i,
    input wire logic [23:0] sample_i,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic dout_o,
    output logic dout_oe_o,
    output logic [4:0] gain_o,
    output logic route_swap_o
);
    logic [31:0] upd_cnt; // Update period timer
    logic [15:0] half_cnt; // Half crystal period timer
    logic half_tick;
    logic [23:0] shreg; // Output shifter
    logic [4:0] bit_cnt; // Bits left
    logic sclk_q; // Previous slave clock
    logic sclk_fall;
    logic sclk_rise;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [23:0] buf_out_data;
    logic conv_done;
    logic load;
    pcar_pkg::pcar_state_t state;
    logic master;
    logic active;
    logic [1:0] wait_halves;
    logic [31:0] lead_cnt; // Cycles spent waiting for the first shift edge
    localparam int LEAD_MIN = HALF_CYC; // Shortest lead-in, half a crystal period
    localparam int LEAD_MAX = 3 * HALF_CYC; // Longest lead-in, three half periods

    assign master = !master_mode_n_i;
    assign active = !chip_select_n_i;

    // Offset binary: flip the sign bit of a twos complement sample
    function automatic logic [23:0] to_offset(input logic [23:0] s);
        return s ^ `PCAR_OFFSET_MSB; // RULE8
    endfunction

    // Fixed update timer stands for the PLL clocked filter decimation
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) upd_cnt <= 32'h0;
        else if (!active || conv_done) upd_cnt <= 32'h0; // RULE13
        else upd_cnt <= upd_cnt + 32'h1; // RULE5 RULE7
    end
    // The notch placement follows from this fixed rate only
    assign conv_done = active && (upd_cnt == 32'(UPDATE_CYC - 1)); // RULE6

    // Half crystal period tick used for the master shift clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) half_cnt <= 16'h0;
        else if (half_tick || state != pcar_pkg::PCAR_WAIT && state != pcar_pkg::PCAR_SHIFT) half_cnt <= 16'h0;
        else half_cnt <= half_cnt + 16'h1;
    end
    assign half_tick = (half_cnt == 16'(HALF_CYC - 1));

    // Slave clock edge detect; inputs are already synchronous
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) sclk_q <= 1'b1;
        else sclk_q <= sclk_i;
    end
    assign sclk_fall = sclk_q && !sclk_i;
    assign sclk_rise = !sclk_q && sclk_i;

    // Buffer keeps a finished result while the shifter is busy
    pcar_buf #(.WIDTH(`PCAR_RESULT_BITS)) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(!active), // RULE13
        .in_valid_i(conv_done),
        .in_ready_o(buf_in_ready),
        .in_data_i(to_offset(sample_i)), // RULE1 RULE8
        .out_valid_o(buf_out_valid),
        .out_ready_i(load),
        .out_data_o(buf_out_data)
    );
    // Gated by select so a deselect in the load cycle cannot start a read
    assign load = active && (state == pcar_pkg::PCAR_CONV) && buf_out_valid;

    // Sequencer: convert, announce ready, shift, return high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= pcar_pkg::PCAR_IDLE;
            shreg <= 24'h0;
            bit_cnt <= 5'h0;
            wait_halves <= 2'h0;
            sclk_o <= 1'b1;
            dout_o <= 1'b1;
        end else if (!active) begin
            state <= pcar_pkg::PCAR_IDLE; // RULE13
            shreg <= 24'h0;
            sclk_o <= 1'b1;
            dout_o <= 1'b1;
        end else begin
            unique case (state)
                pcar_pkg::PCAR_IDLE: begin
                    dout_o <= 1'b1; // RULE14
                    state <= pcar_pkg::PCAR_CONV;
                end
                pcar_pkg::PCAR_CONV: begin
                    if (load) begin
                        shreg <= buf_out_data;
                        bit_cnt <= 5'h18;
                        dout_o <= 1'b0; // RULE14
                        wait_halves <= 2'h0;
                        state <= pcar_pkg::PCAR_WAIT;
                    end
                end
                pcar_pkg::PCAR_WAIT: begin
                    // Master: two half periods low before first fall
                    if (master && half_tick) begin
                        wait_halves <= wait_halves + 2'h1;
                        if (wait_halves == 2'h1) begin // RULE10
                            sclk_o <= 1'b0; // RULE15
                            dout_o <= shreg[23]; // RULE16
                            shreg <= {shreg[22:0], 1'b0};
                            bit_cnt <= bit_cnt - 5'h1;
                            state <= pcar_pkg::PCAR_SHIFT;
                        end
                    end else if (!master && sclk_fall) begin // RULE9 RULE14
                        dout_o <= shreg[23];
                        shreg <= {shreg[22:0], 1'b0};
                        bit_cnt <= bit_cnt - 5'h1;
                        state <= pcar_pkg::PCAR_SHIFT;
                    end else if (conv_done) begin
                        dout_o <= 1'b1; // Unread result goes stale
                        state <= pcar_pkg::PCAR_CONV;
                    end
                end
                pcar_pkg::PCAR_SHIFT: begin
                    if (master ? half_tick && !sclk_o : sclk_rise) begin
                        sclk_o <= 1'b1;
                        if (bit_cnt == 5'h0) begin
                            dout_o <= 1'b1; // RULE11
                            state <= pcar_pkg::PCAR_CONV;
                        end
                    end else if (master ? half_tick && sclk_o : sclk_fall) begin
                        sclk_o <= 1'b0; // RULE15 RULE16
                        dout_o <= shreg[23];
                        shreg <= {shreg[22:0], 1'b0};
                        bit_cnt <= bit_cnt - 5'h1;
                    end
                end
            endcase
        end
    end

    // Drivers float in standby; shift clock driven in master only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_oe_o <= 1'b0;
            sclk_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= active; // RULE13 RULE2
            sclk_oe_o <= active && master; // RULE13
        end
    end

    // Pin configuration only, no programmable state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_o <= 5'(`PCAR_GAIN_NARROW);
            route_swap_o <= 1'b0;
        end else begin
            gain_o <= span_select_i ? 5'(`PCAR_GAIN_WIDE) : 5'(`PCAR_GAIN_NARROW); // RULE3 RULE4 RULE12
            route_swap_o <= excitation_route_select_i; // RULE3
        end
    end

    sequence s_load;
        load;
    endsequence
    a_load_low: assert property (@(posedge clk_i) disable iff (rst_i) s_load |=> !dout_o) // RULE14
        else $error("ready did not fall on result");
    a_standby_float: assert property (@(posedge clk_i) disable iff (rst_i) !active |=> !dout_oe_o && !sclk_oe_o) // RULE13
        else $error("lines not floated in standby");
    a_master_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        master && load |=> sclk_o [*2]) // RULE10
        else $error("master clock too early");
    a_gain_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        span_select_i |=> gain_o == 5'h01) // RULE4
        else $error("wrong gain");
    a_narrow_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        !span_select_i |=> gain_o == 5'h10) // RULE12
        else $error("wrong narrow gain");
    a_end_high: assert property (@(posedge clk_i) disable iff (rst_i)
        state == pcar_pkg::PCAR_SHIFT && bit_cnt == 5'h0 && sclk_rise && !master |=> dout_o) // RULE11
        else $error("ready not restored");
    a_route_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        excitation_route_select_i |=> route_swap_o) // RULE3
        else $error("route not followed");
    a_sclk_slave: assert property (@(posedge clk_i) disable iff (rst_i) !master |=> !sclk_oe_o) // RULE2
        else $error("slave drove clock");

    // Lead-in counter for the master check; restarts whenever the wait ends
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) lead_cnt <= 32'h0;
        else if (state != pcar_pkg::PCAR_WAIT) lead_cnt <= 32'h0;
        else lead_cnt <= lead_cnt + 32'h1;
    end

    // First falling shift edge of a master read, right after the wait
    sequence s_master_first_fall;
        master && state == pcar_pkg::PCAR_SHIFT && bit_cnt == 5'h17 && $fell(sclk_o);
    endsequence
    // The lead-in is checked against both ends, not only the early one
    a_master_lead: assert property (@(posedge clk_i) disable iff (rst_i)
        s_master_first_fall |-> lead_cnt >= LEAD_MIN && lead_cnt <= LEAD_MAX) // RULE10
        else $error("master lead-in outside window");
endmodule // pcar_readout

// file: pcar_host_model.sv
// Host serial port model that reads results over the shared link
module pcar_host_model #(
    parameter int HALF = 3
) (
    input wire logic clk_i,
    input wire logic dout_i,
    input wire logic sclk_i,
    output logic sclk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial sclk_o = 1'b1; // Shift clock idles high between reads
    // Bounded wait for the ready line to fall
    task automatic wait_ready(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 1000 && !ok; i++) begin
            @(posedge clk_i);
            ok = (dout_i === 1'b0);
        end
    endtask
    // Slave read: host clocks the word and samples on each rise
    task automatic read_slave(output logic [23:0] w);
        bit ok;
        w = 'x;
        wait_ready(ok);
        for (int b = 0; b < 24 && ok; b++) begin
            sclk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            w = {w[22:0], dout_i};
            // Longer pause after each byte, which the link must tolerate
            repeat ((b % 8 == 7) ? 8 : 4) @(posedge clk_i);
        end
    endtask
    // Master read: device clocks, model measures lead-in and periods
    task automatic read_master(output logic [23:0] w, output int first, output int bad);
        bit ok;
        int n;
        int last;
        logic prev;
        logic prev_d; // Data seen while the clock was still low
        w = 'x;
        first = -1;
        bad = 0;
        n = 0;
        last = 0;
        prev = 1'b1;
        prev_d = 1'b1;
        wait_ready(ok);
        for (int c = 1; c < 1000 && ok && n < 24; c++) begin
            @(posedge clk_i);
            if (first < 0 && sclk_i === 1'b0) begin
                first = c;
            end
            if (sclk_i === 1'b1 && prev === 1'b0) begin
                if (n > 0 && c - last != 2 * HALF) begin
                    bad++;
                end
                last = c;
                // Take the bit that stood up to the rise; ready may rise with it
                w = {w[22:0], prev_d};
                n++;
            end
            prev = sclk_i;
            prev_d = dout_i;
        end
    endtask
endmodule // pcar_host_model

// file: testbench.sv
// Self-checking testbench for the converter readout block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int UPD = 600; // Shortened update period, longer than a read
    localparam int HALF = 3; // Shortened half crystal period
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n = 1'b1; // Standby until a test selects the device
    logic mode_n = 1'b1;
    logic span = 1'b0;
    logic route = 1'b0;
    logic [23:0] sample = 24'h000000;
    logic host_sclk, sclk_o, sclk_oe_o, dout_o, dout_oe_o, route_swap_o;
    logic [4:0] gain_o;
    wire logic sclk_wire = sclk_oe_o ? sclk_o : host_sclk; // Shared shift clock pin
    // A released data pin shows the inverse, so a stale bit cannot pass
    wire logic dout_wire = dout_oe_o ? dout_o : ~dout_o;
    int failures = 0;
    int check_count = 0;
    // Clock generator
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    pcar_readout #(.UPDATE_CYC(UPD), .HALF_CYC(HALF)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .chip_select_n_i(cs_n), .master_mode_n_i(mode_n), .span_select_i(span),
        .excitation_route_select_i(route), .sample_i(sample), .sclk_i(sclk_wire), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe_o), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .gain_o(gain_o),
        .route_swap_o(route_swap_o));
    pcar_host_model #(.HALF(HALF)) host (.clk_i(clk_i), .dout_i(dout_wire), .sclk_i(sclk_wire),
        .sclk_o(host_sclk));
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Compare a bit vector result
    task automatic cmp_bits(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare a measured count against a window
    task automatic cmp_int(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One selected session: configure, read one word, deselect
    task automatic run_read(input logic m, input logic s, input logic r, input logic [23:0] smp,
        input logic [4:0] g);
        logic [23:0] w;
        int first;
        int bad;
        @(posedge clk_i);
        mode_n <= m;
        span <= s;
        route <= r;
        sample <= smp;
        cs_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_bits({19'h0, gain_o}, {19'h0, g});
        cmp_bits({23'h0, route_swap_o}, {23'h0, r});
        cmp_bits({22'h0, dout_oe_o, sclk_oe_o}, {22'h0, 1'b1, ~m});
        if (m) begin
            host.read_slave(w);
        end else begin
            host.read_master(w, first, bad);
            cmp_int(first, HALF, 3 * HALF);
            cmp_int(bad, 0, 0);
        end
        // Result must come back offset binary, most significant bit first
        cmp_bits(w, smp ^ 24'h800000);
        repeat (4) @(posedge clk_i);
        cmp_bits({23'h0, dout_wire}, 24'h000001);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmp_bits({22'h0, dout_oe_o, sclk_oe_o}, 24'h000000);
        $display("test done mode_n=%0b span=%0b", m, s);
    endtask
    // Main sequence: both modes, both spans, both routes, boundary codes
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        run_read(1'b1, 1'b0, 1'b1, 24'h000001, 5'h10);
        run_read(1'b1, 1'b1, 1'b0, 24'hFFFFFF, 5'h01);
        run_read(1'b0, 1'b0, 1'b0, 24'h123456, 5'h10);
        run_read(1'b0, 1'b1, 1'b1, 24'h7FFFFF, 5'h01);
        close_out();
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("MISMATCH %0t watchdog expired", $time);
        close_out();
    end
endmodule // testbench
